// >>> rtl/charger_regs.sv
// Charger command registers, status and trickle/DAC drive
// Functional notes
// - Slave only, Write-Word only, never initiates
// - Answer address 0x09, write byte 0x12
// - Command 0x12 loads mode word
// - Mode bit0 inhibits charge, sets flag
// - Mode bit2 presets setpoints, clears alarm and overtemp flags
// - Mode bit5 masks pack-detect edge interrupt
// - Mode bit6 masks power-fail edge interrupt
// - Mode bit10 lets overtemp halt charging
// - No pack forces overtemp_halt_enable enable
// - Command 0x15 loads voltage setpoint
// - Voltage low four bits ignored
// - In range: DAC takes bits 13..4
// - Over range: DAC full, flag set
// - Voltage resets to 0xFFF0
// - No pack restores voltage reset value
// - Command 0x14 loads current setpoint
// - Strap selects maximum current range
// - Trickle source 0..31 mA from word
// - Low compensation comparator stops trickle
// - Clamp activity reads voltage-not-regulating
// - Current 32+ keeps trickle at 31
// - Rail strap: bit5 forces coarse bit0
// - Regulator off: gates at safe levels
`timescale 1ns/10ps
`include "charger_defs.svh"
module charger_regs (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_N,
    input  wire logic        PACK_DETECTED,
    input  wire logic        POWER_FAIL,
    input  wire logic        OVERTEMP_FLAG,
    input  wire logic        SENSE_UNDERRANGE_FLAG,
    input  wire logic        VOLT_COMP_LOW,
    input  wire logic        CLAMP_ACTIVE,
    input  wire logic [1:0]  SEL_STRAP,
    output logic [15:0]      MODE_CONTROL_WORD,
    output logic [15:0]      VOLTAGE_SETPOINT_WORD,
    output logic [15:0]      CURRENT_SETPOINT_WORD,
    output logic [9:0]       VOLT_DAC,
    output logic             VOLTAGE_OVER_RANGE,
    output logic [5:0]       COARSE_DAC,
    output logic             REGULATOR_ON,
    output logic [4:0]       TRICKLE_SOURCE,
    output logic             CHARGE_OFF_FLAG,
    output logic             ALARM_HALT_FLAG,
    output logic             OVERTEMP_STATUS,
    output logic             VOLT_LOOP_CLAMPED,
    output logic             IRQ_EVENT,
    output logic             HIGH_GATE_DRIVE,
    output logic             LOW_GATE_DRIVE
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic       scl_s, sda_s, pack_s, pfail_s, hot_s, ur_s, low_s, clamp_s;
    logic [1:0] sel_s;
    pin_sync #(.W(10)) u_sync (
        .CLK (CLK),
        .RST (RST),
        .CE  (CE),
        .d   ({SCL, SDA_IN, PACK_DETECTED, POWER_FAIL, OVERTEMP_FLAG,
                SENSE_UNDERRANGE_FLAG, VOLT_COMP_LOW, CLAMP_ACTIVE, SEL_STRAP}),
        .q   ({scl_s, sda_s, pack_s, pfail_s, hot_s, ur_s, low_s, clamp_s, sel_s})
    );

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic                      wr_valid;
    charger_pkg::word_write_t  wr;
    assign SDA_OUT = 1'b0;
    word_slave u_slave (
        .CLK      (CLK),
        .RST      (RST),
        .CE       (CE),
        .scl      (scl_s),
        .sda      (sda_s),
        .sda_oe_n (SDA_OE_N),
        .wr_valid (wr_valid),
        .wr       (wr)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] mode_reg, volt_reg, curr_reg;
    logic        inhibit_reg, alarm_reg, hot_clr_reg, pack_d, pfail_d, irq_reg;
    logic        w_mode, w_volt, w_curr, preset;
    // mode decode; voltage; current; others ignored
    assign w_mode = wr_valid && wr.cmd == `CMD_MODE;
    assign w_volt = wr_valid && wr.cmd == `CMD_VOLTAGE;
    assign w_curr = wr_valid && wr.cmd == `CMD_CURRENT;
    assign preset = w_mode && wr.data[`MB_PRESET];

    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_reg <= `MODE_POR;
        end else if (CE) begin
            if (w_mode) begin
                mode_reg <= wr.data;
            end
            if (!pack_s) begin
                mode_reg[`MB_OVERTEMP_HALT_ENABLE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            volt_reg <= `VOLT_POR;
        end else if (CE) begin
            if (!pack_s) begin
                volt_reg <= `VOLT_POR;
            end else if (preset) begin
                volt_reg <= `VOLT_PRESET;
            end else if (w_volt) begin
                volt_reg <= wr.data;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            curr_reg <= `CURR_POR;
        end else if (CE) begin
            if (preset) begin
                curr_reg <= `CURR_PRESET;
            end else if (w_curr) begin
                curr_reg <= wr.data;
            end
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            inhibit_reg <= 1'b0;
            alarm_reg   <= 1'b0;
            hot_clr_reg <= 1'b0;
        end else if (CE) begin
            if (w_mode) begin
                inhibit_reg <= wr.data[`MB_INHIBIT];
            end
            if (preset) begin
                alarm_reg   <= 1'b0;
                hot_clr_reg <= 1'b1;
            end else if (!hot_s) begin
                hot_clr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pack_d  <= 1'b0;
            pfail_d <= 1'b0;
            irq_reg <= 1'b0;
        end else if (CE) begin
            pack_d  <= pack_s;
            pfail_d <= pfail_s;
            irq_reg <= ((pack_s ^ pack_d) && !mode_reg[`MB_PACK_MASK])
                    || ((pfail_s ^ pfail_d) && !mode_reg[`MB_PFAIL_MASK]);
        end
    end

    // ----------------------------------------
    // DAC and trickle drive
    // ----------------------------------------
    logic hot_eff, halt, over, regon;
    logic [5:0] coarse;
    assign hot_eff = hot_s && !hot_clr_reg;
    assign halt = inhibit_reg || alarm_reg
               || (hot_eff && mode_reg[`MB_OVERTEMP_HALT_ENABLE] && !ur_s);
    assign over = volt_reg[15] | volt_reg[14];

    // strap picks coarse field; rail strap bit 5
    always_comb begin
        unique case (sel_s)
            `SEL_GND:  coarse = {curr_reg[9:5], 1'b0};
            `SEL_OPEN: coarse = curr_reg[10:5];
            default:   coarse = {curr_reg[11:7], curr_reg[6] | curr_reg[5]};
        endcase
    end
    assign regon = !halt && (curr_reg[15:5] != 11'h000) && (volt_reg[15:4] != 12'h000);

    always_ff @(posedge CLK) begin
        if (RST) begin
            VOLT_DAC           <= `DAC_FULL;
            VOLTAGE_OVER_RANGE <= 1'b1;
            COARSE_DAC         <= 6'h00;
            REGULATOR_ON       <= 1'b0;
            TRICKLE_SOURCE     <= 5'h00;
        end else if (CE) begin
            // low nibble dropped; in-range mapping; saturate
            VOLT_DAC           <= over ? `DAC_FULL : volt_reg[13:4];
            VOLTAGE_OVER_RANGE <= over;
            REGULATOR_ON       <= regon;
            if (regon) begin
                COARSE_DAC <= coarse;
            end
            // trickle; cap at 31; comparator cut-off; clamp override
            if (halt || (volt_reg[15:4] == 12'h000) || (low_s && !clamp_s)) begin
                TRICKLE_SOURCE <= 5'h00;
            end else if (curr_reg[15:5] != 11'h000) begin
                TRICKLE_SOURCE <= `TRICKLE_MAX;
            end else begin
                TRICKLE_SOURCE <= curr_reg[4:0];
            end
        end
    end

    assign HIGH_GATE_DRIVE = 1'b0;
    assign LOW_GATE_DRIVE  = 1'b0;

    assign MODE_CONTROL_WORD     = mode_reg;
    assign VOLTAGE_SETPOINT_WORD = volt_reg;
    assign CURRENT_SETPOINT_WORD = curr_reg;
    assign CHARGE_OFF_FLAG       = inhibit_reg;
    assign ALARM_HALT_FLAG       = alarm_reg;
    assign OVERTEMP_STATUS       = hot_eff;
    assign VOLT_LOOP_CLAMPED     = clamp_s;
    assign IRQ_EVENT             = irq_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence no_pack_s;
        !pack_s;
    endsequence
    AST_HOT_FORCE: assert property (@(posedge CLK) disable iff (RST)
        (CE and no_pack_s) |=> mode_reg[`MB_OVERTEMP_HALT_ENABLE])
        else $error("overtemp_halt_enable not forced");
    AST_VOLT_RESTORE: assert property (@(posedge CLK) disable iff (RST)
        (CE and no_pack_s) |=> volt_reg == `VOLT_POR)
        else $error("voltage not restored");
    AST_OVER: assert property (@(posedge CLK) disable iff (RST)
        (CE && over) |=> VOLT_DAC == `DAC_FULL && VOLTAGE_OVER_RANGE)
        else $error("over range not saturated");
    AST_INRANGE: assert property (@(posedge CLK) disable iff (RST)
        (CE && !over) |=> VOLT_DAC == $past(volt_reg[13:4]) && !VOLTAGE_OVER_RANGE)
        else $error("dac mapping wrong");
    AST_TRICKLE_CAP: assert property (@(posedge CLK) disable iff (RST)
        (CE && !halt && volt_reg[15:4] != 12'h000 && !(low_s && !clamp_s)
            && curr_reg[15:5] != 11'h000) |=> TRICKLE_SOURCE == `TRICKLE_MAX)
        else $error("trickle not held at cap");
    AST_LOW_CUT: assert property (@(posedge CLK) disable iff (RST)
        (CE && low_s && !clamp_s) |=> TRICKLE_SOURCE == 5'h00)
        else $error("trickle not cut");
    AST_INHIBIT: assert property (@(posedge CLK) disable iff (RST)
        (CE && w_mode) |=> CHARGE_OFF_FLAG == $past(wr.data[`MB_INHIBIT]))
        else $error("inhibit flag wrong");
    AST_PRESET: assert property (@(posedge CLK) disable iff (RST)
        (CE && preset && pack_s) |=> volt_reg == `VOLT_PRESET && curr_reg == `CURR_PRESET)
        else $error("preset failed");
    AST_PACK_IRQ: assert property (@(posedge CLK) disable iff (RST)
        (CE && (pack_s ^ pack_d) && !mode_reg[`MB_PACK_MASK]) |=> IRQ_EVENT)
        else $error("pack edge missed");
    AST_IGNORE: assert property (@(posedge CLK) disable iff (RST)
        (CE && pack_s && wr_valid && !w_mode && !w_volt && !w_curr)
        |=> $stable(volt_reg) && $stable(curr_reg))
        else $error("unknown command changed state");
    sequence volt_load_s;
        CE && w_volt && pack_s;
    endsequence
    AST_VOLT_WRITE: assert property (@(posedge CLK) disable iff (RST)
        volt_load_s |=> volt_reg == $past(wr.data))
        else $error("voltage write lost");
    AST_CURR_WRITE: assert property (@(posedge CLK) disable iff (RST)
        (CE && w_curr) |=> curr_reg == $past(wr.data))
        else $error("current write lost");
    AST_MODE_WRITE: assert property (@(posedge CLK) disable iff (RST)
        (CE && w_mode && pack_s) |=> mode_reg == $past(wr.data))
        else $error("mode write lost");
    AST_HOT_HALT: assert property (@(posedge CLK) disable iff (RST)
        (CE && hot_eff && mode_reg[`MB_OVERTEMP_HALT_ENABLE] && !ur_s)
        |=> TRICKLE_SOURCE == 5'h00 && !REGULATOR_ON)
        else $error("overtemp did not halt");
    AST_PFAIL_IRQ: assert property (@(posedge CLK) disable iff (RST)
        (CE && (pfail_s ^ pfail_d) && !mode_reg[`MB_PFAIL_MASK]) |=> IRQ_EVENT)
        else $error("power-fail edge missed");
    AST_COARSE_HOLD: assert property (@(posedge CLK) disable iff (RST)
        (CE && !regon) |=> $stable(COARSE_DAC))
        else $error("coarse dac moved while off");
endmodule : charger_regs

// >>> pkg/charger_defs.svh
// Constants of the charger command and set-point logic
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH
`define SLAVE_ADDR          7'h09
`define CMD_MODE            8'h12
`define CMD_CURRENT         8'h14
`define CMD_VOLTAGE         8'h15
`define MODE_POR            16'hff54
`define VOLT_POR            16'hfff0
`define VOLT_PRESET         16'hffff
`define CURR_PRESET         16'h00c0
`define CURR_POR            16'h0000
`define MB_INHIBIT          0
`define MB_PRESET           2
`define MB_PACK_MASK        5
`define MB_PFAIL_MASK       6
`define MB_OVERTEMP_HALT_ENABLE         10
`define TRICKLE_MAX         5'h1f
`define DAC_FULL            10'h3ff
`define SEL_GND             2'h0
`define SEL_OPEN            2'h1
`define SEL_RAIL            2'h2
`endif

// >>> pkg/charger_pkg.sv
// Types shared by the charger command logic
package charger_pkg;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] data;
    } word_write_t;
    typedef struct packed {
        logic high_gate_drive;
        logic low_gate_drive;
    } gate_t;
endpackage : charger_pkg

// >>> rtl/pin_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic         CE,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge CLK) begin
        if (RST) begin
            meta_reg <= '0;
            q        <= '0;
        end else if (CE) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : pin_sync

// >>> rtl/word_slave.sv
// Two-wire bus slave that accepts Write-Word transactions
`timescale 1ns/10ps
`include "charger_defs.svh"
module word_slave (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    input  wire logic                  CE,
    input  wire logic                  scl,
    input  wire logic                  sda,
    output logic                       sda_oe_n,
    output logic                       wr_valid,
    output charger_pkg::word_write_t   wr
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_ADDR = 3'b001, S_CMD = 3'b010,
        S_LO = 3'b011, S_HI = 3'b100, S_WAIT = 3'b101
    } st_t;
    st_t         st_reg;
    logic        scl_d, sda_d, ack_reg, byte_done;
    logic [3:0]  cnt_reg;
    logic [7:0]  sh_reg, cmd_reg, lo_reg;
    logic        rise, fall, start, stop;
    assign rise  = scl & ~scl_d;
    assign fall  = ~scl & scl_d;
    assign start = scl & scl_d & sda_d & ~sda;
    assign stop  = scl & scl_d & ~sda_d & sda;
    assign byte_done = (cnt_reg == 4'h8);
    assign sda_oe_n = ~ack_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (CE) begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_reg   <= S_IDLE;
            cnt_reg  <= 4'h0;
            sh_reg   <= 8'h00;
            cmd_reg  <= 8'h00;
            lo_reg   <= 8'h00;
            ack_reg  <= 1'b0;
            wr_valid <= 1'b0;
            wr       <= '0;
        end else if (CE) begin
            wr_valid <= 1'b0;
            if (start) begin
                st_reg  <= S_ADDR;
                cnt_reg <= 4'h0;
                ack_reg <= 1'b0;
            end else if (stop) begin
                if (st_reg == S_WAIT) begin
                    wr_valid <= 1'b1;
                    wr.cmd   <= cmd_reg;
                    wr.data  <= {sh_reg, lo_reg};
                end
                st_reg  <= S_IDLE;
                ack_reg <= 1'b0;
            end else if (rise && st_reg != S_IDLE && st_reg != S_WAIT && !byte_done) begin
                sh_reg  <= {sh_reg[6:0], sda};
                cnt_reg <= cnt_reg + 4'h1;
            end else if (fall && byte_done && !ack_reg && st_reg != S_IDLE
                         && st_reg != S_WAIT) begin
                unique case (st_reg)
                    S_ADDR: ack_reg <= (sh_reg == {`SLAVE_ADDR, 1'b0});
                    default: ack_reg <= 1'b1;
                endcase
                if (st_reg == S_ADDR && sh_reg != {`SLAVE_ADDR, 1'b0}) begin
                    st_reg <= S_IDLE;
                end
            end else if (fall && ack_reg) begin
                ack_reg <= 1'b0;
                cnt_reg <= 4'h0;
                unique case (st_reg)
                    S_ADDR: st_reg <= S_CMD;
                    S_CMD: begin
                        cmd_reg <= sh_reg;
                        st_reg  <= S_LO;
                    end
                    S_LO: begin
                        lo_reg <= sh_reg;
                        st_reg <= S_HI;
                    end
                    S_HI:   st_reg <= S_WAIT;
                    default: st_reg <= S_IDLE;
                endcase
            end
        end
    end

    AST_IDLE_QUIET: assert property (@(posedge CLK) disable iff (RST)
        (st_reg == S_IDLE) |-> sda_oe_n)
        else $error("acknowledge while idle");
endmodule : word_slave

// >>> test/smbus_host.sv
// Bus master model that issues Write-Word frames
`timescale 1ns/10ps
module smbus_host (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ------------------------------------------------------------
    // Byte transfer
    // ------------------------------------------------------------
    // MSB first bits
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #20 sda_pull = ~b[i];
            #20 scl = 1'b1;
            #40 scl = 1'b0;
        end
        #20 sda_pull = 1'b0;
        #20 scl = 1'b1;
        #20 ack = ~sda;
        #20 scl = 1'b0;
    endtask : put

    // ------------------------------------------------------------
    // Whole frame
    // ------------------------------------------------------------
    // start, address, command, low then high byte
    task automatic frame(input logic [7:0] adr, input logic [7:0] cmd,
                         input logic [15:0] d, input logic stop,
                         output logic [3:0] acks);
        #20 sda_pull = 1'b0;
        #20 scl = 1'b1;
        #20 sda_pull = 1'b1;
        #20 scl = 1'b0;
        put(adr, acks[3]);
        put(cmd, acks[2]);
        put(d[7:0], acks[1]);
        put(d[15:8], acks[0]);
        if (stop) begin
            #20 sda_pull = 1'b1;
            #20 scl = 1'b1;
            #20 sda_pull = 1'b0;
        end
    endtask : frame
endmodule : smbus_host

// >>> test/tb_charger_regs.sv
// Self-checking bench for the charger command registers
`timescale 1ns/10ps
`include "charger_defs.svh"
module tb_charger_regs;
    // unimplemented mode bits as the master must write them
    localparam logic [15:0] FIX = 16'hfb90;
    logic        clk, rst, pack, pfail, hot, vlow, clamp, ur;
    logic [1:0]  strap;
    logic        scl, sda_pull, sda_oe_n, sda;
    logic [15:0] mode_w, volt_w, curr_w;
    logic [9:0]  vdac;
    logic [5:0]  cdac;
    logic [4:0]  trk;
    logic        vor, reg_on, off_f, alarm_f, hot_s, clamped, irq, hg, lg;
    logic [3:0]  acks;
    int          num_errors, comparisons, irqs;

    assign sda = ~(sda_pull | ~sda_oe_n);
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    always @(negedge clk) if (irq === 1'b1) irqs++;

    charger_regs i_charger_regs (.CLK(clk), .RST(rst), .CE(1'b1), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N(sda_oe_n), .PACK_DETECTED(pack),
        .POWER_FAIL(pfail), .OVERTEMP_FLAG(hot), .SENSE_UNDERRANGE_FLAG(ur),
        .VOLT_COMP_LOW(vlow), .CLAMP_ACTIVE(clamp), .SEL_STRAP(strap),
        .MODE_CONTROL_WORD(mode_w), .VOLTAGE_SETPOINT_WORD(volt_w),
        .CURRENT_SETPOINT_WORD(curr_w), .VOLT_DAC(vdac), .VOLTAGE_OVER_RANGE(vor),
        .COARSE_DAC(cdac), .REGULATOR_ON(reg_on), .TRICKLE_SOURCE(trk),
        .CHARGE_OFF_FLAG(off_f), .ALARM_HALT_FLAG(alarm_f), .OVERTEMP_STATUS(hot_s),
        .VOLT_LOOP_CLAMPED(clamped), .IRQ_EVENT(irq), .HIGH_GATE_DRIVE(hg),
        .LOW_GATE_DRIVE(lg));
    smbus_host i_smbus_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_smbus_host.frame(8'h12, c, d, 1'b1, acks);
        check(16'(acks), 16'h000f);
        wait_clk(10);
    endtask : wr

    task automatic wrap_up;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check(mode_w, 16'hff54);
        check(volt_w, 16'hfff0);
        check(curr_w, 16'h0000);
        check(16'({vor, vdac}), 16'h07ff);
        check(16'({hg, lg, trk}), 16'h0000);
    endtask : t_reset

    task automatic t_pack;
        irqs = 0;
        pack = 1'b1;
        wait_clk(8);
        check(16'(irqs), 16'h0001);
        pfail = 1'b1;
        wait_clk(8);
        pfail = 1'b0;
        wait_clk(8);
        check(16'(irqs), 16'h0001);
        wr(`CMD_MODE, FIX | 16'h0400);
        check(mode_w, FIX | 16'h0400);
        pfail = 1'b1;
        wait_clk(8);
        pfail = 1'b0;
        wait_clk(8);
        check(16'(irqs), 16'h0003);
    endtask : t_pack

    task automatic t_refuse;
        i_smbus_host.frame(8'h10, `CMD_VOLTAGE, 16'h1230, 1'b1, acks);
        check(16'(acks[3]), 16'h0000);
        i_smbus_host.frame(8'h13, `CMD_VOLTAGE, 16'h1230, 1'b1, acks);
        check(16'(acks[3]), 16'h0000);
        wr(8'h13, 16'h1230);
        i_smbus_host.frame(8'h12, `CMD_VOLTAGE, 16'h1230, 1'b0, acks);
        wait_clk(10);
        check(volt_w, 16'hfff0);
        wr(`CMD_VOLTAGE, 16'h1230);
        check(volt_w, 16'h1230);
    endtask : t_refuse

    task automatic t_volt;
        logic [15:0] v [4];
        v = '{16'h123f, 16'h4000, 16'h8010, 16'h3fff};
        for (int k = 0; k < 4; k++) begin
            wr(`CMD_VOLTAGE, v[k]);
            check(volt_w, v[k]);
            check(16'(vdac), (v[k][15] | v[k][14]) ? 16'h03ff : 16'(v[k][13:4]));
            check(16'(vor), 16'(v[k][15] | v[k][14]));
        end
    endtask : t_volt

    task automatic t_curr;
        logic [15:0] c [4];
        logic [5:0]  e;
        c = '{16'h0005, 16'h0020, 16'h0040, 16'h0060};
        for (int s = 0; s < 3; s++) begin
            strap = 2'(s);
            wait_clk(8);
            for (int k = 0; k < 4; k++) begin
                wr(`CMD_CURRENT, c[k]);
                check(curr_w, c[k]);
                check(16'(trk), c[k] < 16'h0020 ? c[k] : 16'h001f);
                check(16'(reg_on), 16'(c[k] >= 16'h0020));
                e = s == 0 ? {c[k][9:5], 1'b0} : s == 1 ? c[k][10:5]
                    : {c[k][11:7], c[k][6] | c[k][5]};
                if (c[k] >= 16'h0020) check(16'(cdac), 16'(e));
            end
        end
        wr(`CMD_CURRENT, 16'h0005);
    endtask : t_curr

    task automatic t_comp;
        vlow = 1'b1;
        wait_clk(8);
        check(16'(trk), 16'h0000);
        clamp = 1'b1;
        wait_clk(8);
        check(16'({clamped, trk}), 16'h0025);
        vlow = 1'b0;
        clamp = 1'b0;
        wait_clk(8);
    endtask : t_comp

    task automatic t_hot;
        hot = 1'b1;
        wait_clk(8);
        check(16'(trk), 16'h0000);
        ur = 1'b1;
        wait_clk(8);
        check(16'(trk), 16'h0005);
        ur = 1'b0;
        wait_clk(8);
        check(16'(trk), 16'h0000);
        wr(`CMD_MODE, FIX);
        check(16'(trk), 16'h0005);
        wr(`CMD_MODE, FIX | 16'h0404);
        check(volt_w, 16'hffff);
        check(curr_w, 16'h00c0);
        check(16'({hot_s, alarm_f, trk}), 16'h001f);
        hot = 1'b0;
        wait_clk(8);
    endtask : t_hot

    task automatic t_inhibit;
        wr(`CMD_MODE, FIX | 16'h0401);
        check(16'({off_f, trk}), 16'h0020);
        wr(`CMD_MODE, FIX | 16'h0400);
        check(16'({off_f, trk}), 16'h001f);
    endtask : t_inhibit

    task automatic t_remove;
        wr(`CMD_MODE, FIX);
        check(16'(mode_w[10]), 16'h0000);
        irqs = 0;
        pack = 1'b0;
        wait_clk(8);
        check(16'(irqs), 16'h0001);
        check(16'(mode_w[10]), 16'h0001);
        check(volt_w, 16'hfff0);
        wr(`CMD_VOLTAGE, 16'h1230);
        check(volt_w, 16'hfff0);
    endtask : t_remove

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, pack, pfail, hot, vlow, clamp} = 6'h20;
        strap = 2'h1;
        ur = 1'b0;
        num_errors = 0;
        comparisons = 0;
        wait_clk(4);
        rst = 1'b0;
        wait_clk(4);
        t_reset;
        t_pack;
        t_refuse;
        t_volt;
        t_curr;
        t_comp;
        t_hot;
        t_inhibit;
        t_remove;
        wrap_up;
    end

    initial begin
        #250000;
        num_errors++;
        wrap_up;
    end
endmodule : tb_charger_regs
